/* logic/spsc_filter.sv */
// synchroniser and debounce filter for one carrier input
// assumes the raw input may change at any time
`timescale 1ns/1ps
module spsc_filter #(
	parameter int LIMIT = spsc_pkg::FILTER_CYCLES,
	parameter logic INIT = 1'b1
) (
	input logic clk_i,
	input logic rst_i,
	input logic raw_i,
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);

	localparam logic [spsc_pkg::CNT_W-1:0] LIM1 = spsc_pkg::CNT_W'(LIMIT - 1);

	logic sync1_reg, sync1_next, sync2_reg, sync2_next;
	logic level_reg, level_next, rise_reg, rise_next, fall_reg, fall_next;
	logic [spsc_pkg::CNT_W-1:0] cnt_reg, cnt_next;

	// ----------------------------------------------------------------
	// filter
	// ----------------------------------------------------------------
	// level follows only after the synced input differs for LIMIT cycles
	always_comb begin
		sync1_next = raw_i;
		sync2_next = sync1_reg;
		level_next = level_reg;
		cnt_next = cnt_reg;
		if (sync2_reg == level_reg) begin
			cnt_next = '0; // any glitch restarts the count
		end else if (cnt_reg == LIM1) begin
			level_next = sync2_reg;
			cnt_next = '0;
		end else begin
			cnt_next = cnt_reg + 1'b1;
		end
		rise_next = level_next & ~level_reg;
		fall_next = ~level_next & level_reg;
	end

	// register stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_reg <= INIT;
			sync2_reg <= INIT;
			level_reg <= INIT;
			rise_reg <= 1'b0;
			fall_reg <= 1'b0;
			cnt_reg <= '0;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
			level_reg <= level_next;
			rise_reg <= rise_next;
			fall_reg <= fall_next;
			cnt_reg <= cnt_next;
		end
	end

	assign level_o = level_reg;
	assign rise_o = rise_reg;
	assign fall_o = fall_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_filt_hold;
		@(posedge clk_i) disable iff (rst_i)
		$changed(level_reg) |-> $past(cnt_reg) == LIM1 && $past(sync2_reg) != $past(level_reg);
	endproperty
	a_filt_hold: assert property (p_filt_hold) else $error("filter level moved early");

endmodule

/* logic/spsc_pkg.sv */
// constants, register map and state type of the power state control block
// assumes a single 125 MHz clock and a synchronous active high reset
package spsc_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 125000000;
	localparam int FILTER_MS = 16;
	localparam int FILTER_CYCLES = CLK_HZ / 1000 * FILTER_MS;
	localparam int HOLD_US = 100;
	localparam int RESET_CYCLES = CLK_HZ / 1000000 * HOLD_US;
	localparam int WARN_US = 10;
	localparam int WARN_CYCLES = CLK_HZ / 1000000 * WARN_US;
	localparam int CNT_W = 22;
	localparam logic [CNT_W-1:0] WARN_LOAD = CNT_W'(WARN_CYCLES - 1);

	// ----------------------------------------------------------------
	// filtered inputs, event bits share the same positions
	// ----------------------------------------------------------------
	localparam int N_IN = 8;
	localparam int IN_PWR = 0;
	localparam int IN_RST = 1;
	localparam int IN_COVER = 2;
	localparam int IN_DOZE = 3;
	localparam int IN_PCIE_WAKE_IN_N = 4;
	localparam int IN_GENERAL_WAKE_IN_N = 5;
	localparam int IN_BATTERY_LOW_IN_N = 6;
	localparam int IN_PG = 7;
	localparam logic [N_IN-1:0] IN_INIT = 8'h7f;

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_EVT = 8'h08;
	localparam logic [7:0] REG_EVT_CLR = 8'h0c;
	localparam logic [7:0] REG_EVT_EN = 8'h10;
	localparam int CTRL_AUTO_DOZE = 0;
	localparam int CTRL_SLEEP = 1;
	localparam int CTRL_OFF = 2;
	localparam int STAT_ON = 8;
	localparam int STAT_SLEEP = 9;
	localparam int STAT_OFF = 10;
	localparam logic CTRL_RST = 1'b0;
	localparam logic [N_IN-1:0] EVT_EN_RST = 8'h00;

	typedef enum logic [2:0] {
		S_OFF,
		S_POWER_UP,
		S_RESET,
		S_ON,
		S_WARN,
		S_SLEEP
	} spsc_state_type;

endpackage

/* logic/spsc_top.sv */
// power and system state control with a classic Wishbone register slave
// assumes carrier inputs are asynchronous and pass a two stage sync
`timescale 1ns/1ps
module spsc_top #(
	parameter int FILTER_CYCLES = spsc_pkg::FILTER_CYCLES,
	parameter int RESET_CYCLES = spsc_pkg::RESET_CYCLES
) (
	input logic clk_i,
	input logic rst_i,
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [7:0] wb_adr_i,
	input logic [3:0] wb_sel_i,
	input logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input logic power_button_n_i,
	input logic reset_button_n_i,
	input logic cover_switch_n_i,
	input logic doze_button_n_i,
	input logic pcie_wake_in_n_i,
	input logic general_wake_in_n_i,
	input logic battery_low_in_n_i,
	input logic power_good_in_i,
	output logic suspend_warning_n_o,
	output logic suspend_ram_ind_n_o,
	output logic suspend_disk_ind_n_o,
	output logic soft_off_ind_n_o,
	output logic carrier_reset_out_n_o,
	output logic irq_o
);

	localparam logic [spsc_pkg::CNT_W-1:0] RESET_LOAD = spsc_pkg::CNT_W'(RESET_CYCLES - 1);

	logic [spsc_pkg::N_IN-1:0] raw_w, lvl_w, rise_w, fall_w;

	// ----------------------------------------------------------------
	// input filters
	// ----------------------------------------------------------------
	// one sync and debounce stage per carrier input
	assign raw_w = {power_good_in_i, battery_low_in_n_i, general_wake_in_n_i,
		pcie_wake_in_n_i, doze_button_n_i, cover_switch_n_i, reset_button_n_i,
		power_button_n_i};

	for (genvar g = 0; g < spsc_pkg::N_IN; g++) begin : g_filt
		spsc_filter #(
			.LIMIT(FILTER_CYCLES),
			.INIT(spsc_pkg::IN_INIT[g])
		) u_filt (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.raw_i(raw_w[g]),
			.level_o(lvl_w[g]),
			.rise_o(rise_w[g]),
			.fall_o(fall_w[g])
		);
	end

	// ----------------------------------------------------------------
	// register bus slave
	// ----------------------------------------------------------------
	logic ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;
	logic ctrl_reg, ctrl_next;
	logic [spsc_pkg::N_IN-1:0] evt_reg, evt_next, en_reg, en_next, evt_set;
	logic irq_reg, irq_next;
	logic wr_w, sleep_req_w, off_req_w;
	spsc_pkg::spsc_state_type state_reg, state_next;

	// writes land on the edge where the master sees ack
	assign wr_w = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & wb_sel_i[0];
	assign sleep_req_w = wr_w && wb_adr_i == spsc_pkg::REG_CTRL
		&& wb_dat_i[spsc_pkg::CTRL_SLEEP];
	assign off_req_w = wr_w && wb_adr_i == spsc_pkg::REG_CTRL
		&& wb_dat_i[spsc_pkg::CTRL_OFF];

	// ack, read data, control, events and interrupt
	always_comb begin
		ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
		dat_next = 32'h0;
		if (ack_next) begin
			unique case (wb_adr_i)
				spsc_pkg::REG_CTRL: dat_next = {31'h0, ctrl_reg};
				spsc_pkg::REG_STATUS: begin
					dat_next[spsc_pkg::N_IN-1:0] = lvl_w;
					dat_next[spsc_pkg::STAT_ON] = state_reg == spsc_pkg::S_ON;
					dat_next[spsc_pkg::STAT_SLEEP] = state_reg == spsc_pkg::S_SLEEP;
					dat_next[spsc_pkg::STAT_OFF] = state_reg == spsc_pkg::S_OFF;
				end
				spsc_pkg::REG_EVT: dat_next = {24'h0, evt_reg};
				spsc_pkg::REG_EVT_EN: dat_next = {24'h0, en_reg};
				default: dat_next = 32'h0; // clear register and holes read zero
			endcase
		end
		ctrl_next = ctrl_reg;
		en_next = en_reg;
		evt_next = evt_reg;
		if (wr_w && wb_adr_i == spsc_pkg::REG_CTRL) begin
			ctrl_next = wb_dat_i[spsc_pkg::CTRL_AUTO_DOZE];
		end
		if (wr_w && wb_adr_i == spsc_pkg::REG_EVT_EN) begin
			en_next = wb_dat_i[spsc_pkg::N_IN-1:0];
		end
		if (wr_w && wb_adr_i == spsc_pkg::REG_EVT_CLR) begin
			evt_next = evt_reg & ~wb_dat_i[spsc_pkg::N_IN-1:0];
		end
		// falls are presses; cover reports both ways; pg fall is power fail
		evt_set = fall_w;
		evt_set[spsc_pkg::IN_COVER] = fall_w[spsc_pkg::IN_COVER]
			| rise_w[spsc_pkg::IN_COVER];
		evt_next = evt_next | evt_set; // set wins over clear
		irq_next = |(evt_next & en_next);
	end

	// register stage of the bus slave
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0;
			ctrl_reg <= spsc_pkg::CTRL_RST;
			en_reg <= spsc_pkg::EVT_EN_RST;
			evt_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
			dat_reg <= dat_next;
			ctrl_reg <= ctrl_next;
			en_reg <= en_next;
			evt_reg <= evt_next;
			irq_reg <= irq_next;
		end
	end

	// ----------------------------------------------------------------
	// power state machine
	// ----------------------------------------------------------------
	logic [spsc_pkg::CNT_W-1:0] timer_reg, timer_next;
	logic to_off_reg, to_off_next;
	logic warn_n_reg, warn_n_next, ram_n_reg, ram_n_next;
	logic off_n_reg, off_n_next, cbr_n_reg, cbr_n_next;
	logic pg_w, doze_w;

	assign pg_w = lvl_w[spsc_pkg::IN_PG];
	assign doze_w = ctrl_reg & fall_w[spsc_pkg::IN_DOZE];

	// next state, timer and pin levels
	always_comb begin
		state_next = state_reg;
		timer_next = timer_reg;
		to_off_next = to_off_reg;
		unique case (state_reg)
			spsc_pkg::S_OFF: begin
				if (fall_w[spsc_pkg::IN_PWR]) begin
					state_next = spsc_pkg::S_POWER_UP;
				end
			end
			spsc_pkg::S_POWER_UP: begin
				if (pg_w) begin
					state_next = spsc_pkg::S_RESET;
					timer_next = RESET_LOAD;
				end
			end
			spsc_pkg::S_RESET: begin
				// fixed hold, button level is never looked at
				if (!pg_w) begin
					state_next = spsc_pkg::S_POWER_UP;
				end else if (timer_reg == '0) begin
					state_next = spsc_pkg::S_ON;
				end else begin
					timer_next = timer_reg - 1'b1;
				end
			end
			spsc_pkg::S_ON: begin
				if (!pg_w) begin
					state_next = spsc_pkg::S_POWER_UP;
				end else if (fall_w[spsc_pkg::IN_RST]) begin
					state_next = spsc_pkg::S_RESET;
					timer_next = RESET_LOAD;
				end else if (off_req_w | sleep_req_w | doze_w) begin
					state_next = spsc_pkg::S_WARN;
					timer_next = spsc_pkg::WARN_LOAD;
					to_off_next = off_req_w;
				end
			end
			spsc_pkg::S_WARN: begin
				if (timer_reg == '0) begin
					state_next = to_off_reg ? spsc_pkg::S_OFF : spsc_pkg::S_SLEEP;
				end else begin
					timer_next = timer_reg - 1'b1;
				end
			end
			spsc_pkg::S_SLEEP: begin
				if (fall_w[spsc_pkg::IN_PCIE_WAKE_IN_N] | fall_w[spsc_pkg::IN_GENERAL_WAKE_IN_N]
					| doze_w | fall_w[spsc_pkg::IN_PWR]) begin
					state_next = spsc_pkg::S_POWER_UP;
				end
			end
		endcase
		warn_n_next = !(state_next inside {spsc_pkg::S_WARN, spsc_pkg::S_SLEEP,
			spsc_pkg::S_OFF});
		ram_n_next = state_next != spsc_pkg::S_SLEEP;
		off_n_next = state_next != spsc_pkg::S_OFF;
		cbr_n_next = state_next == spsc_pkg::S_ON && pg_w;
	end

	// register stage of the state machine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= spsc_pkg::S_OFF;
			timer_reg <= '0;
			to_off_reg <= 1'b0;
			warn_n_reg <= 1'b0;
			ram_n_reg <= 1'b1;
			off_n_reg <= 1'b0;
			cbr_n_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			to_off_reg <= to_off_next;
			warn_n_reg <= warn_n_next;
			ram_n_reg <= ram_n_next;
			off_n_reg <= off_n_next;
			cbr_n_reg <= cbr_n_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign irq_o = irq_reg;
	assign suspend_warning_n_o = warn_n_reg;
	assign suspend_ram_ind_n_o = ram_n_reg;
	assign suspend_disk_ind_n_o = 1'b1;
	assign soft_off_ind_n_o = off_n_reg;
	assign carrier_reset_out_n_o = cbr_n_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_pwr_up;
		state_reg == spsc_pkg::S_OFF && fall_w[spsc_pkg::IN_PWR] |=>
			state_reg == spsc_pkg::S_POWER_UP;
	endproperty
	a_pwr_up: assert property (p_pwr_up) else $error("power button ignored");

	property p_rst_edge;
		state_reg == spsc_pkg::S_ON && pg_w && fall_w[spsc_pkg::IN_RST] |=>
			state_reg == spsc_pkg::S_RESET && !carrier_reset_out_n_o;
	endproperty
	a_rst_edge: assert property (p_rst_edge) else $error("reset edge missed");

	property p_rst_free;
		state_reg == spsc_pkg::S_RESET && timer_reg == '0 && pg_w |=>
			state_reg == spsc_pkg::S_ON && carrier_reset_out_n_o;
	endproperty
	a_rst_free: assert property (p_rst_free) else $error("reset held too long");

	property p_warn_first;
		$fell(suspend_ram_ind_n_o) |-> !$past(suspend_warning_n_o, 8);
	endproperty
	a_warn_first: assert property (p_warn_first) else $error("no warning before sleep");

	property p_ram_ind;
		suspend_ram_ind_n_o == (state_reg != spsc_pkg::S_SLEEP);
	endproperty
	a_ram_ind: assert property (p_ram_ind) else $error("ram indicator wrong");

	property p_disk_ind;
		suspend_disk_ind_n_o;
	endproperty
	a_disk_ind: assert property (p_disk_ind) else $error("disk indicator asserted");

	property p_off_ind;
		soft_off_ind_n_o == (state_reg != spsc_pkg::S_OFF);
	endproperty
	a_off_ind: assert property (p_off_ind) else $error("soft-off indicator wrong");

	property p_pcie_wake_in_n;
		state_reg == spsc_pkg::S_SLEEP && fall_w[spsc_pkg::IN_PCIE_WAKE_IN_N] |=>
			state_reg == spsc_pkg::S_POWER_UP && suspend_ram_ind_n_o;
	endproperty
	a_pcie_wake_in_n: assert property (p_pcie_wake_in_n) else $error("pcie wake ignored");

	property p_general_wake_in_n;
		state_reg == spsc_pkg::S_SLEEP && fall_w[spsc_pkg::IN_GENERAL_WAKE_IN_N] |=>
			state_reg == spsc_pkg::S_POWER_UP;
	endproperty
	a_general_wake_in_n: assert property (p_general_wake_in_n) else $error("general wake ignored");

	property p_battery_low_in_n;
		fall_w[spsc_pkg::IN_BATTERY_LOW_IN_N] |=> evt_reg[spsc_pkg::IN_BATTERY_LOW_IN_N];
	endproperty
	a_battery_low_in_n: assert property (p_battery_low_in_n) else $error("battery low not flagged");

	property p_cover;
		$changed(lvl_w[spsc_pkg::IN_COVER]) |=> evt_reg[spsc_pkg::IN_COVER];
	endproperty
	a_cover: assert property (p_cover) else $error("cover change not flagged");

	property p_doze;
		fall_w[spsc_pkg::IN_DOZE] |=> evt_reg[spsc_pkg::IN_DOZE];
	endproperty
	a_doze: assert property (p_doze) else $error("doze press not flagged");

	property p_cbr;
		!pg_w |=> !carrier_reset_out_n_o;
	endproperty
	a_cbr: assert property (p_cbr) else $error("carrier reset released without power");

	c_boot: cover property (state_reg == spsc_pkg::S_RESET ##1 state_reg == spsc_pkg::S_ON);
	c_sleep: cover property (state_reg == spsc_pkg::S_WARN ##1 state_reg == spsc_pkg::S_SLEEP);
	c_resume: cover property (state_reg == spsc_pkg::S_SLEEP ##1
		state_reg == spsc_pkg::S_POWER_UP);
	c_off: cover property (state_reg == spsc_pkg::S_WARN ##1 state_reg == spsc_pkg::S_OFF);

endmodule

/* testbench/spsc_carrier.sv */
// carrier board model: buttons, wake and battery lines, power supply
// assumes the block's indicators are driven from reset onward
`timescale 1ns/1ps
module spsc_carrier (
	input wire logic clk_i,
	input wire logic soft_off_ind_n_i,
	input wire logic suspend_ram_ind_n_i,
	output logic [6:0] btn_n_o,
	output logic power_good_o
);
	int ramp;
	// --------------------------------
	// supply and pins
	// --------------------------------
	// idle pins sit at their pull-up level
	initial begin
		btn_n_o = 7'h7f;
		power_good_o = 1'b0;
		ramp = 0;
	end
	// rails are up while the soft-off and RAM indicators are both high, good after a 20 cycle ramp
	always @(posedge clk_i) begin
		if (soft_off_ind_n_i === 1'b1 && suspend_ram_ind_n_i === 1'b1) begin
			ramp <= (ramp < 20) ? ramp + 1 : 20;
		end else begin
			ramp <= 0;
		end
		power_good_o <= (ramp == 20);
	end
	// one pin driven just after an edge
	task automatic set_pin(input int idx, input logic v);
		@(posedge clk_i);
		btn_n_o[idx] <= v;
	endtask
	// press for len cycles, then idle 16 cycles
	task automatic press(input int idx, input int len);
		set_pin(idx, 1'b0);
		repeat (len) @(posedge clk_i);
		btn_n_o[idx] <= 1'b1;
		repeat (16) @(posedge clk_i);
	endtask
endmodule

/* testbench/spsc_top_tb.sv */
// self-checking bench of the power state control block
// assumes filter and reset hold shortened to 8 and 16 cycles
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module spsc_top_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rd, rdat;
	logic ack, warn_n, ram_n, disk_n, off_n, crst_n, irq, pg;
	logic [6:0] btn_n;
	logic [4:0] mon;
	int n_errors = 0;
	int n_tests = 0;
	int seed = 31;
	int cycles = 0;
	int m_evt, k, wk;
	assign mon = {warn_n, irq, off_n, ram_n, crst_n};
	spsc_top #(.FILTER_CYCLES(8), .RESET_CYCLES(16)) spsc_top_i (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rd), .wb_ack_o(ack), .power_button_n_i(btn_n[0]),
		.reset_button_n_i(btn_n[1]), .cover_switch_n_i(btn_n[2]), .doze_button_n_i(btn_n[3]),
		.pcie_wake_in_n_i(btn_n[4]), .general_wake_in_n_i(btn_n[5]),
		.battery_low_in_n_i(btn_n[6]), .power_good_in_i(pg), .suspend_warning_n_o(warn_n),
		.suspend_ram_ind_n_o(ram_n), .suspend_disk_ind_n_o(disk_n), .soft_off_ind_n_o(off_n),
		.carrier_reset_out_n_o(crst_n), .irq_o(irq));
	spsc_carrier spsc_carrier_i (.clk_i(clk_i), .soft_off_ind_n_i(off_n),
		.suspend_ram_ind_n_i(ram_n), .btn_n_o(btn_n), .power_good_o(pg));
	// --------------------------------
	// clock, timeout, tasks
	// --------------------------------
	// 125 MHz clock
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	// cut a hang short
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			give_verdict();
		end
	end
	// report and stop
	task automatic give_verdict;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// classic single cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0);
		`CHK(nm, e, rdat)
	endtask
	// bounded wait for a monitored output
	task automatic wait_for(input int i, input logic v, input int n, input string nm);
		int j;
		for (j = 0; j < n && mon[i] !== v; j++) @(posedge clk_i);
		`CHK(nm, v, mon[i])
	endtask
	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(spsc_pkg::REG_CTRL, 32'h0, "ctrl rst");
		rd_chk(spsc_pkg::REG_EVT_EN, 32'h0, "evt_en rst");
		// short glitch is dropped
		spsc_carrier_i.press(0, 1 + $unsigned($random(seed)) % 6);
		repeat (20) @(posedge clk_i);
		`CHK("soft_off", 1'b0, off_n)
		`CHK("disk", 1'b1, disk_n)
		rd_chk(spsc_pkg::REG_EVT, 32'h0, "evt glitch");
		// power up from soft-off
		spsc_carrier_i.press(0, 16);
		wait_for(0, 1'b1, 300, "crst on");
		`CHK("soft_off on", 1'b1, off_n)
		rd_chk(spsc_pkg::REG_STATUS, 32'h1ff, "status on");
		m_evt = 1;
		rd_chk(spsc_pkg::REG_EVT, m_evt, "evt pwr");
		// reset button held low: one reset, then run on
		spsc_carrier_i.set_pin(1, 1'b0);
		wait_for(0, 1'b0, 40, "crst rst");
		wait_for(0, 1'b1, 80, "crst held");
		spsc_carrier_i.set_pin(1, 1'b1);
		// cover level shows in status
		spsc_carrier_i.set_pin(2, 1'b0);
		repeat (20) @(posedge clk_i);
		rd_chk(spsc_pkg::REG_STATUS, 32'h1fb, "status cover");
		spsc_carrier_i.set_pin(2, 1'b1);
		repeat (20) @(posedge clk_i);
		// events raise, mask and clear the interrupt
		for (k = 2; k <= 6; k += 4) begin
			m_evt = 1 << k;
			wb(1'b1, spsc_pkg::REG_EVT_CLR, 32'hff);
			wb(1'b1, spsc_pkg::REG_EVT_EN, 32'(m_evt));
			spsc_carrier_i.press(k, 16);
			wait_for(3, 1'b1, 40, "irq set");
			rd_chk(spsc_pkg::REG_EVT, m_evt, "evt bit");
			wb(1'b1, spsc_pkg::REG_EVT_EN, 32'h0);
			wait_for(3, 1'b0, 3, "irq mask");
			wb(1'b1, spsc_pkg::REG_EVT_EN, 32'(m_evt));
			wait_for(3, 1'b1, 3, "irq unmask");
			wb(1'b1, spsc_pkg::REG_EVT_CLR, 32'(m_evt));
			wait_for(3, 1'b0, 3, "irq clear");
		end
		// sleep by register or doze, wake by pcie wake, general wake or doze
		for (k = 0; k < 3; k++) begin
			wk = (k == 2) ? 3 : 4 + k;
			if (k == 2) begin
				wb(1'b1, spsc_pkg::REG_CTRL, 32'h1);
				spsc_carrier_i.press(3, 16);
			end else begin
				wb(1'b1, spsc_pkg::REG_CTRL, 32'h2);
			end
			wait_for(4, 1'b0, 60, "warn");
			`CHK("ram warn", 1'b1, ram_n)
			wait_for(1, 1'b0, 1400, "ram sleep");
			`CHK("crst sleep", 1'b0, crst_n)
			spsc_carrier_i.press(wk, 16);
			wait_for(0, 1'b1, 300, "crst wake");
			`CHK("ram wake", 1'b1, ram_n)
			`CHK("warn wake", 1'b1, warn_n)
		end
		// off request
		wb(1'b1, spsc_pkg::REG_CTRL, 32'h4);
		wait_for(2, 1'b0, 1400, "off");
		`CHK("ram off", 1'b1, ram_n)
		`CHK("disk off", 1'b1, disk_n)
		`CHK("warn off", 1'b0, warn_n)
		// unmapped and write-only places read zero
		wb(1'b1, 8'h3c, $random(seed));
		rd_chk(8'h3c, 32'h0, "unmapped");
		rd_chk(spsc_pkg::REG_EVT_CLR, 32'h0, "evt_clr read");
		give_verdict();
	end
endmodule
